// ===== rtl/meip_event_irq.sv
// Event flags, interrupt enables and end-event broadcast for the microphone block.
// Assumes Avalon-MM master holds each request until waitrequest is seen low,
// and that the sampling engine gives one-cycle event pulses on i_mclk.
module meip_event_irq
    import meip_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [11:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_transfer_started,
    input wire logic i_transfer_stopped,
    input wire logic i_transfer_end,
    output logic o_irq,
    output logic o_bcast_pulse,
    output logic [15:0] o_bcast_channel
);

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // Every access takes one wait cycle, so read data is registered; write decode is combinational.
    meip_bus_t bus_q;
    logic req;
    logic wr_acc;
    logic [31:0] wdata;

    assign req = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & (bus_q == MEIP_IDLE);
    assign wr_acc = i_avs_write & (bus_q == MEIP_ACK);

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    assign wdata = i_avs_writedata & lane_mask(i_avs_byteenable);

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            bus_q <= MEIP_IDLE;
        end else begin
            unique case (bus_q)
                MEIP_IDLE: begin
                    if (req) begin
                        bus_q <= MEIP_ACK;
                    end
                end
                MEIP_ACK: begin
                    bus_q <= MEIP_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Broadcast configuration
    // ----------------------------------------------------------------
    logic [15:0] channel_index_q;
    logic bcast_en_q;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            channel_index_q <= CHANNEL_INDEX_RST;
            bcast_en_q <= BCAST_EN_RST;
        end else if (wr_acc && i_avs_address == OFF_BCAST_CFG) begin
            if (i_avs_byteenable[0]) begin
                channel_index_q[7:0] <= i_avs_writedata[7:0];
            end
            if (i_avs_byteenable[1]) begin
                channel_index_q[15:8] <= i_avs_writedata[15:8];
            end
            if (i_avs_byteenable[3]) begin
                bcast_en_q <= i_avs_writedata[BCAST_EN_BIT];
            end
        end
    end

    // The channel output is registered so it never glitches with the pulse.
    logic bcast_pulse_q;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            bcast_pulse_q <= 1'b0;
        end else begin
            bcast_pulse_q <= i_transfer_end & bcast_en_q;
        end
    end

    assign o_bcast_pulse = bcast_pulse_q;
    assign o_bcast_channel = channel_index_q;

    // ----------------------------------------------------------------
    // Interrupt enables
    // ----------------------------------------------------------------
    logic [2:0] irq_en_q;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            irq_en_q <= IRQ_EN_RST;
        end else if (wr_acc && i_avs_byteenable[0]) begin
            unique case (i_avs_address)
                OFF_IRQ_ENABLE: irq_en_q <= i_avs_writedata[EV_W-1:0];
                // Only ones act on the aliases; zeros keep the stored enables.
                OFF_IRQ_ENABLE_SET: irq_en_q <= irq_en_q | wdata[EV_W-1:0];
                OFF_IRQ_ENABLE_CLEAR: irq_en_q <= irq_en_q & ~wdata[EV_W-1:0];
                default: irq_en_q <= irq_en_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Event flags
    // ----------------------------------------------------------------
    logic [2:0] flags_q;
    logic [2:0] ev_in;
    logic [2:0] ev_clr;

    assign ev_in[EV_STARTED] = i_transfer_started;
    assign ev_in[EV_STOPPED] = i_transfer_stopped;
    assign ev_in[EV_END] = i_transfer_end;
    assign ev_clr = (wr_acc && i_avs_address == OFF_EVENT_CLEAR) ? wdata[EV_W-1:0] : 3'h0;

    // A new event in the clearing cycle wins, so no event is lost.
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= (flags_q & ~ev_clr) | ev_in;
        end
    end

    assign o_irq = |(flags_q & irq_en_q);

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (i_avs_address)
            OFF_BCAST_CFG: begin
                rdata_d[CHANNEL_INDEX_W-1:0] = channel_index_q;
                rdata_d[BCAST_EN_BIT] = bcast_en_q;
            end
            OFF_IRQ_ENABLE, OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR: begin
                rdata_d[EV_W-1:0] = irq_en_q;
            end
            OFF_EVENT_FLAGS: rdata_d[EV_W-1:0] = flags_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            rdata_q <= 32'h0000_0000;
        end else if (i_avs_read && bus_q == MEIP_IDLE) begin
            rdata_q <= rdata_d;
        end
    end

    assign o_avs_readdata = rdata_q;

endmodule

// ===== rtl/meip_pkg.sv
// Package for the microphone event signalling block: offsets, fields, resets.
// Assumes a 32-bit Avalon-MM slave with byte addresses.
package meip_pkg;

    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_BCAST_CFG = 12'h188;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h300;
    localparam logic [11:0] OFF_IRQ_ENABLE_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR = 12'h308;
    localparam logic [11:0] OFF_EVENT_FLAGS = 12'h310;
    localparam logic [11:0] OFF_EVENT_CLEAR = 12'h314;

    // Field layout of the broadcast configuration.
    localparam int CHANNEL_INDEX_LSB = 0;
    localparam int CHANNEL_INDEX_W = 16;
    localparam int BCAST_EN_BIT = 31;

    // Event bit positions, shared by enable, flag and clear registers.
    localparam int EV_STARTED = 0;
    localparam int EV_STOPPED = 1;
    localparam int EV_END = 2;
    localparam int EV_W = 3;

    localparam logic [15:0] CHANNEL_INDEX_RST = 16'h0000;
    localparam logic BCAST_EN_RST = 1'b0;
    localparam logic [2:0] IRQ_EN_RST = 3'h0;
    localparam logic [2:0] FLAGS_RST = 3'h0;

    typedef enum logic [0:0] {
        MEIP_IDLE = 1'b0,
        MEIP_ACK = 1'b1
    } meip_bus_t;

endpackage

// ===== test/meip_event_irq_props.sv
// Checker for the event and interrupt block, bound to its top ports.
// Assumes a bus master that holds each request until waitrequest is low.
module meip_event_irq_props (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_transfer_started,
    input wire logic i_transfer_stopped,
    input wire logic i_transfer_end,
    input wire logic o_irq,
    input wire logic o_bcast_pulse,
    input wire logic [15:0] o_bcast_channel
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);
    wire logic req = i_avs_read | i_avs_write;
    wire logic ev = i_transfer_started | i_transfer_stopped | i_transfer_end;
    a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest)
        else $error("no wait cycle");
    a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("wait too long");
    a_rdata_hold: assert property (!$past(i_avs_read || i_srst) |-> $stable(o_avs_readdata))
        else $error("read data moved");
    a_chan_hold: assert property (!$past(i_avs_write || i_srst) |-> $stable(o_bcast_channel))
        else $error("channel moved");
    a_bcast_cause: assert property (o_bcast_pulse |-> $past(i_transfer_end))
        else $error("stray broadcast");
    a_irq_cause: assert property ($rose(o_irq) |-> $past(ev || i_avs_write))
        else $error("stray interrupt");
    a_irq_hold: assert property (o_irq && !i_avs_write |=> o_irq)
        else $error("interrupt dropped");
    a_irq_fall: assert property ($fell(o_irq) |-> $past(i_avs_write || i_srst))
        else $error("interrupt fell");
    c_irq_rise: cover property ($rose(o_irq));
    c_irq_fall: cover property ($fell(o_irq));
    c_bcast: cover property (o_bcast_pulse);
endmodule

// ===== test/meip_event_src.sv
// Model of the sampling engine: turns a fire request into one-cycle event pulses.
// Assumes the bench raises each fire bit for a single cycle of i_mclk.
module meip_event_src (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [2:0] i_fire,
    output logic o_started,
    output logic o_stopped,
    output logic o_end
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_mclk) begin
        o_started <= !i_srst && i_fire[0];
        o_stopped <= !i_srst && i_fire[1];
        o_end <= !i_srst && i_fire[2];
    end
endmodule

// ===== test/tb_meip_event_irq.sv
// Bench for the event and interrupt block: register tests over the bus.
// Assumes the event source model and the checker bound at the foot.
module tb_meip_event_irq import meip_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, srst = 1, rd = 0, wr = 0;
    logic [11:0] addr = '0;
    logic [31:0] wd = '0, q;
    logic [2:0] fire = '0;
    wire logic [31:0] rdata;
    wire logic wreq, irq, bp, st, sp, en;
    wire logic [15:0] bch;
    int bad_count = 0, samples_checked = 0, cyc = 0, npulse = 0;
    meip_event_irq i_dut (.i_mclk(clk), .i_srst(srst), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_transfer_started(st),
        .i_transfer_stopped(sp), .i_transfer_end(en), .o_irq(irq), .o_bcast_pulse(bp),
        .o_bcast_channel(bch));
    meip_event_src i_src (.i_mclk(clk), .i_srst(srst), .i_fire(fire), .o_started(st),
        .o_stopped(sp), .o_end(en));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // The bench timeout alone ends a wait, so a hung slave still reaches the verdict.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (bp === 1'b1) npulse <= npulse + 1;
        if (cyc == 3000) begin
            bad_count++;
            results();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input bit w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wd <= d;
        do @(negedge clk); while (wreq !== 1'b0);
        @(posedge clk);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic ev(input int i);
        @(posedge clk);
        fire <= 3'h1 << i;
        @(posedge clk);
        fire <= 3'h0;
        repeat (3) @(posedge clk);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        acc(0, OFF_BCAST_CFG, 0); chk("cfg_rst", q, 0);
        for (int i = 0; i < 3; i++) begin
            acc(0, OFF_IRQ_ENABLE + 12'(4 * i), 0); chk("en_rst", q, 0);
        end
        acc(1, OFF_BCAST_CFG, 32'h8000_a5c3); acc(0, OFF_BCAST_CFG, 0);
        chk("cfg", q, 32'h8000_a5c3); chk("chan", {16'h0, bch}, 32'h0000_a5c3);
        ev(EV_END); chk("pulse_on", npulse, 1);
        acc(1, OFF_BCAST_CFG, 32'h0000_a5c3); ev(EV_END); chk("pulse_off", npulse, 1);
        $display("broadcast test done");
        for (int i = 0; i < 3; i++) begin
            acc(1, OFF_IRQ_ENABLE_SET, 32'h1 << i); acc(0, OFF_IRQ_ENABLE, 0);
            chk("set", q, (32'h2 << i) - 1);
        end
        acc(1, OFF_IRQ_ENABLE_SET, 0); acc(1, OFF_IRQ_ENABLE_CLEAR, 0);
        acc(0, OFF_IRQ_ENABLE_SET, 0); chk("zero", q, 32'h7);
        acc(1, OFF_IRQ_ENABLE_CLEAR, 32'h1); acc(0, OFF_IRQ_ENABLE_CLEAR, 0);
        chk("clr0", q, 32'h6);
        acc(1, OFF_IRQ_ENABLE_CLEAR, 32'h4); acc(0, OFF_IRQ_ENABLE, 0); chk("clr2", q, 32'h2);
        $display("enable test done");
        chk("irq_masked", irq, 0);
        ev(EV_STOPPED); chk("irq_on", irq, 1);
        ev(EV_STARTED); acc(0, OFF_EVENT_FLAGS, 0); chk("flags", q, 32'h7);
        acc(1, OFF_IRQ_ENABLE, 32'h4); acc(0, OFF_IRQ_ENABLE, 0); chk("direct", q, 32'h4);
        acc(1, OFF_EVENT_CLEAR, 32'h7); @(posedge clk); chk("irq_off", irq, 0);
        acc(1, 12'h0fc, 32'hffff_ffff); acc(0, 12'h0fc, 0); chk("unmapped", q, 0);
        $display("interrupt test done");
        results();
    end
endmodule
bind meip_event_irq meip_event_irq_props i_props (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_transfer_started(i_transfer_started),
    .i_transfer_stopped(i_transfer_stopped), .i_transfer_end(i_transfer_end), .o_irq(o_irq),
    .o_bcast_pulse(o_bcast_pulse), .o_bcast_channel(o_bcast_channel));
